// >>> rtl/serial_link_pkg.sv
// types shared by the serial link transmitter
package serial_link_pkg;
    typedef enum logic [2:0] {
        st_off,
        st_cgs,
        st_ila,
        st_data,
        st_test
    } tx_state_type;
endpackage

// >>> rtl/serial_link_regs.svh
// register offsets, field codes, characters and counts of the serial link tx
//
// Behaviour
// - selector zero sends normal sample data
// - codes 1-5: prbs7, prbs15, prbs23, ramp, transport
// - codes 6-9: d21.5, k28.5, repeated ila, rpat
// - code 10 holds low, 11 high
// - identifier sent in second ila multiframe
// - link a sends identifier, link b plus one
// - identifier bit zero ignored, reads zero
// - end-of-frame char: k28.7, k28.1, k28.5
// - end-of-frame char replaces any repeated octet at any frame position, k28.3 at multiframe end
// - link disabled holds framing and lane outputs in reset; the sample buffer is not cleared and takes samples until its two entries are full
`ifndef SERIAL_LINK_REGS_SVH
`define SERIAL_LINK_REGS_SVH

// register indices; byte address is four times the index
`define IDX_LINK_CTRL     12'h200
`define IDX_TEST_SEL      12'h205
`define IDX_DEV_ID        12'h206
`define IDX_FRAME_END     12'h207
`define IDX_TX_STATUS     12'h20f
`define RST_LINK_CTRL     1'h0
`define RST_TEST_SEL      4'h0
`define RST_DEV_ID        8'h00
`define RST_FRAME_END     2'h0

// test selector codes
`define TST_NONE          4'h0
`define TST_PRBS7         4'h1
`define TST_PRBS15        4'h2
`define TST_PRBS23        4'h3
`define TST_RAMP          4'h4
`define TST_TRANSPORT     4'h5
`define TST_D215          4'h6
`define TST_K285          4'h7
`define TST_ILA           4'h8
`define TST_RPAT          4'h9
`define TST_LOW           4'ha
`define TST_HIGH          4'hb

// characters before 8b/10b coding
`define CHR_D215          8'hb5
`define CHR_K280          8'h1c
`define CHR_K281          8'h3c
`define CHR_K283          8'h7c
`define CHR_K284          8'h9c
`define CHR_K285          8'hbc
`define CHR_K287          8'hfc

// frames per multiframe minus one, multiframes of alignment, pattern
`define FRAMES_M1         5'h1f
`define ILA_MF_LAST       2'h3
`define RPAT_LAST         4'hb
`define PRBS_SEED         23'h7fffff

`endif

// >>> rtl/serial_link_tx.sv
// serial link transmitter: apb registers, pattern generator, framing
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "serial_link_regs.svh"

module serial_link_tx
    import serial_link_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    input  wire logic [7:0]  sample_data,
    input  wire logic        sync_n,
    input  wire logic        sysref,
    input  wire logic        lane_ready,
    output logic             lane_valid,
    output logic      [7:0]  lane_a_data,
    output logic      [7:0]  lane_b_data,
    output logic             lane_is_k,
    output logic             serial_hold_low,
    output logic             serial_hold_high,
    output logic             serializer_on
);

    // ****************************************************************
    // register file
    // ****************************************************************
    logic        link_enable_q, link_enable_d;
    logic [3:0]  test_sel_q, test_sel_d;
    logic [7:0]  dev_id_q, dev_id_d;
    logic [1:0]  frame_end_sel_q, frame_end_sel_d;
    logic [31:0] prdata_q, prdata_d;
    logic [11:0] reg_idx;
    logic        mapped;
    logic [7:0]  status_byte;
    tx_state_type st_q, st_d;
    logic        sync_n_s;

    assign reg_idx = paddr[13:2];
    assign mapped  = (paddr[1:0] == 2'b00) &&
                     (reg_idx == `IDX_LINK_CTRL || reg_idx == `IDX_TEST_SEL ||
                      reg_idx == `IDX_DEV_ID || reg_idx == `IDX_FRAME_END ||
                      reg_idx == `IDX_TX_STATUS);
    assign status_byte = {2'b00, link_enable_q, sync_n_s, 1'b0, 3'(st_q)};

    // zero wait states: read data is caught in the setup cycle
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_q;

    always_comb begin
        link_enable_d   = link_enable_q;
        test_sel_d      = test_sel_q;
        dev_id_d        = dev_id_q;
        frame_end_sel_d = frame_end_sel_q;
        prdata_d        = prdata_q;
        if (psel && !penable) begin
            case (mapped ? reg_idx : 12'h000)
                `IDX_LINK_CTRL: prdata_d = {31'h0, link_enable_q};
                `IDX_TEST_SEL:  prdata_d = {28'h0, test_sel_q};
                `IDX_DEV_ID:    prdata_d = {24'h0, dev_id_q};
                `IDX_FRAME_END: prdata_d = {30'h0, frame_end_sel_q};
                `IDX_TX_STATUS: prdata_d = {24'h0, status_byte};
                default:        prdata_d = 32'h0;
            endcase
        end
        // settings are taken at any time; host keeps them still while enabled
        if (psel && penable && pwrite && mapped) begin
            case (reg_idx)
                `IDX_LINK_CTRL: link_enable_d = pwdata[0];
                `IDX_TEST_SEL:  test_sel_d = pwdata[3:0];
                `IDX_DEV_ID:    dev_id_d = {pwdata[7:1], 1'b0};
                `IDX_FRAME_END: frame_end_sel_d = pwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_enable_q   <= `RST_LINK_CTRL;
            test_sel_q      <= `RST_TEST_SEL;
            dev_id_q        <= `RST_DEV_ID;
            frame_end_sel_q <= `RST_FRAME_END;
            prdata_q        <= 32'h0;
        end else begin
            link_enable_q   <= link_enable_d;
            test_sel_q      <= test_sel_d;
            dev_id_q        <= dev_id_d;
            frame_end_sel_q <= frame_end_sel_d;
            prdata_q        <= prdata_d;
        end
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] sync_ff_q, sysref_ff_q;
    logic       sysref_prev_q;

    assign sync_n_s = sync_ff_q[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ff_q     <= 2'b00;
            sysref_ff_q   <= 2'b00;
            sysref_prev_q <= 1'b0;
        end else begin
            sync_ff_q     <= {sync_ff_q[0], sync_n};
            sysref_ff_q   <= {sysref_ff_q[0], sysref};
            sysref_prev_q <= sysref_ff_q[1];
        end
    end

    // ****************************************************************
    // two-entry sample buffer
    // ****************************************************************
    logic [7:0] buf_mem_q [2];
    logic [7:0] buf_mem_d [2];
    logic       buf_wr_q, buf_wr_d, buf_rd_q, buf_rd_d;
    logic [1:0] buf_cnt_q, buf_cnt_d;
    logic       buf_push, buf_pop, buf_valid;
    logic [7:0] buf_head;

    assign sample_ready = (buf_cnt_q != 2'd2);
    assign buf_valid    = (buf_cnt_q != 2'd0);
    assign buf_head     = buf_mem_q[buf_rd_q];
    assign buf_push     = sample_valid & sample_ready;

    always_comb begin
        buf_mem_d = buf_mem_q;
        buf_wr_d  = buf_wr_q;
        buf_rd_d  = buf_rd_q;
        buf_cnt_d = buf_cnt_q;
        if (buf_push) begin
            buf_mem_d[buf_wr_q] = sample_data;
            buf_wr_d = ~buf_wr_q;
        end
        if (buf_pop) begin
            buf_rd_d = ~buf_rd_q;
        end
        case ({buf_push, buf_pop})
            2'b10:   buf_cnt_d = buf_cnt_q + 2'd1;
            2'b01:   buf_cnt_d = buf_cnt_q - 2'd1;
            default: buf_cnt_d = buf_cnt_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_mem_q[0] <= 8'h00;
            buf_mem_q[1] <= 8'h00;
            buf_wr_q     <= 1'b0;
            buf_rd_q     <= 1'b0;
            buf_cnt_q    <= 2'd0;
        end else begin
            buf_mem_q <= buf_mem_d;
            buf_wr_q  <= buf_wr_d;
            buf_rd_q  <= buf_rd_d;
            buf_cnt_q <= buf_cnt_d;
        end
    end

    // ****************************************************************
    // pattern helpers
    // ****************************************************************
    // eight serial steps per octet; the seed suits all three lengths
    function automatic logic [30:0] prbs_octet(input logic [22:0] s,
                                               input logic [3:0]  c);
        logic [22:0] t;
        logic [7:0]  o;
        logic        fb;
        t = s;
        o = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case (c)
                `TST_PRBS7:  fb = t[6] ^ t[5];
                `TST_PRBS15: fb = t[14] ^ t[13];
                default:     fb = t[22] ^ t[17];
            endcase
            t = {t[21:0], fb};
            o = {o[6:0], fb};
        end
        return {o, t};
    endfunction

    function automatic logic [7:0] rpat_octet(input logic [3:0] i);
        case (i)
            4'h0:    return 8'hbe;
            4'h1:    return 8'hd7;
            4'h2:    return 8'h23;
            4'h3:    return 8'h47;
            4'h4:    return 8'h6b;
            4'h5:    return 8'h8f;
            4'h6:    return 8'hb3;
            4'h7:    return 8'h14;
            4'h8:    return 8'h5e;
            4'h9:    return 8'hfb;
            4'ha:    return 8'h35;
            default: return 8'h59;
        endcase
    endfunction

    // ****************************************************************
    // transmitter framing and pattern selection
    // ****************************************************************
    logic [4:0]  frame_pos_q, frame_pos_d;
    logic [1:0]  ila_mf_q, ila_mf_d;
    logic [22:0] lfsr_q, lfsr_d;
    logic [7:0]  ramp_q, ramp_d;
    logic [3:0]  rpat_q, rpat_d;
    logic [7:0]  prev_q, prev_d;
    logic [7:0]  a_q, a_d, b_q, b_d;
    logic        k_q, k_d, valid_q, valid_d;
    logic        lo_q, lo_d, hi_q, hi_d;
    logic [30:0] prbs;
    logic [7:0]  end_char;
    logic        mf_end, step, did_slot, sysref_rise;

    assign prbs        = prbs_octet(lfsr_q, test_sel_q);
    assign mf_end      = (frame_pos_q == `FRAMES_M1);
    assign sysref_rise = sysref_ff_q[1] & ~sysref_prev_q;
    // no sample means no octet: the lane stalls instead of inventing data
    assign step        = lane_ready & (st_q != st_data | buf_valid);
    assign buf_pop     = lane_ready & (st_q == st_data) & buf_valid;
    assign did_slot    = (st_q == st_ila) & (ila_mf_q == 2'd1) &
                         (frame_pos_q == 5'd2);

    always_comb begin
        case (frame_end_sel_q)
            2'd1:    end_char = `CHR_K281;
            2'd2:    end_char = `CHR_K285;
            default: end_char = `CHR_K287;
        endcase
    end

    always_comb begin
        st_d        = st_q;
        frame_pos_d = frame_pos_q;
        ila_mf_d    = ila_mf_q;
        lfsr_d      = lfsr_q;
        ramp_d      = ramp_q;
        rpat_d      = rpat_q;
        prev_d      = prev_q;
        a_d         = a_q;
        k_d         = k_q;
        valid_d     = valid_q & ~lane_ready;
        lo_d        = 1'b0;
        hi_d        = 1'b0;
        if (step && st_q != st_off) begin
            frame_pos_d = frame_pos_q + 5'd1;
            valid_d     = 1'b1;
            k_d         = 1'b0;
        end
        case (st_q)
            st_off: begin
                valid_d = 1'b0;
                st_d = (test_sel_q == `TST_NONE) ? st_cgs : st_test;
            end
            st_cgs: begin
                if (step) begin
                    a_d = `CHR_K285;
                    k_d = 1'b1;
                    if (sync_n_s && mf_end) begin
                        st_d     = st_ila;
                        ila_mf_d = 2'd0;
                    end
                end
            end
            st_ila: begin
                if (step) begin
                    a_d = {3'h0, frame_pos_q};
                    if (frame_pos_q == 5'd0) begin
                        a_d = `CHR_K280;
                        k_d = 1'b1;
                    end else if (mf_end) begin
                        a_d = `CHR_K283;
                        k_d = 1'b1;
                    end else if (ila_mf_q == 2'd1 && frame_pos_q == 5'd1) begin
                        a_d = `CHR_K284;
                        k_d = 1'b1;
                    end else if (did_slot) begin
                        a_d = dev_id_q;
                    end
                    if (mf_end) begin
                        ila_mf_d = ila_mf_q + 2'd1;
                        if (ila_mf_q == `ILA_MF_LAST &&
                            test_sel_q != `TST_ILA) begin
                            st_d = st_data;
                        end
                    end
                end
            end
            st_data: begin
                if (!sync_n_s) begin
                    st_d = st_cgs;
                end else if (step) begin
                    a_d    = buf_head;
                    prev_d = buf_head;
                    // swap whenever the octet repeats the previous octet, at any frame position
                    if (buf_head == prev_q) begin
                        a_d = mf_end ? `CHR_K283 : end_char;
                        k_d = 1'b1;
                    end
                end
            end
            st_test: begin
                lo_d = lo_q;
                hi_d = hi_q;
                if (step) begin
                    lo_d = (test_sel_q == `TST_LOW);
                    hi_d = (test_sel_q == `TST_HIGH);
                    case (test_sel_q)
                        `TST_PRBS7, `TST_PRBS15, `TST_PRBS23: begin
                            a_d    = prbs[30:23];
                            lfsr_d = prbs[22:0];
                        end
                        `TST_RAMP: begin
                            a_d    = ramp_q;
                            ramp_d = ramp_q + 8'h01;
                        end
                        `TST_TRANSPORT: a_d = {3'h0, frame_pos_q};
                        `TST_D215:      a_d = `CHR_D215;
                        `TST_K285: begin
                            a_d = `CHR_K285;
                            k_d = 1'b1;
                        end
                        `TST_RPAT: begin
                            a_d    = rpat_octet(rpat_q);
                            rpat_d = (rpat_q == `RPAT_LAST) ? 4'h0 :
                                     rpat_q + 4'h1;
                        end
                        `TST_HIGH:      a_d = 8'hff;
                        default:        a_d = 8'h00;
                    endcase
                end
                // repeated alignment runs through the ila state
                if (test_sel_q == `TST_ILA && mf_end && step) begin
                    st_d     = st_ila;
                    ila_mf_d = 2'd0;
                end
            end
            default: st_d = st_off;
        endcase
        b_d = a_d;
        if (step && did_slot) begin
            b_d = dev_id_q + 8'h01;
        end else if (!step) begin
            b_d = b_q;
        end
        if (sysref_rise) begin
            frame_pos_d = 5'd0;
        end
        // disabled link: framing and lane outputs held in reset (sample buffer keeps running), sysref ignored
        if (!link_enable_q) begin
            st_d        = st_off;
            frame_pos_d = 5'd0;
            ila_mf_d    = 2'd0;
            lfsr_d      = `PRBS_SEED;
            ramp_d      = 8'h00;
            rpat_d      = 4'h0;
            prev_d      = 8'h00;
            a_d         = 8'h00;
            b_d         = 8'h00;
            k_d         = 1'b0;
            valid_d     = 1'b0;
            lo_d        = 1'b0;
            hi_d        = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q        <= st_off;
            frame_pos_q <= 5'd0;
            ila_mf_q    <= 2'd0;
            lfsr_q      <= `PRBS_SEED;
            ramp_q      <= 8'h00;
            rpat_q      <= 4'h0;
            prev_q      <= 8'h00;
            a_q         <= 8'h00;
            b_q         <= 8'h00;
            k_q         <= 1'b0;
            valid_q     <= 1'b0;
            lo_q        <= 1'b0;
            hi_q        <= 1'b0;
        end else begin
            st_q        <= st_d;
            frame_pos_q <= frame_pos_d;
            ila_mf_q    <= ila_mf_d;
            lfsr_q      <= lfsr_d;
            ramp_q      <= ramp_d;
            rpat_q      <= rpat_d;
            prev_q      <= prev_d;
            a_q         <= a_d;
            b_q         <= b_d;
            k_q         <= k_d;
            valid_q     <= valid_d;
            lo_q        <= lo_d;
            hi_q        <= hi_d;
        end
    end

    assign lane_valid       = valid_q;
    assign lane_a_data      = a_q;
    assign lane_b_data      = b_q;
    assign lane_is_k        = k_q;
    assign serial_hold_low  = lo_q;
    assign serial_hold_high = hi_q;
    assign serializer_on    = link_enable_q;

endmodule
`default_nettype wire

// >>> tb/lane_receiver_model.sv
// far end receiver: random stalls, releases sync after a run of commas
`timescale 1ns/100ps
`default_nettype none
module lane_receiver_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       stall,
    input  wire logic       lane_valid,
    input  wire logic [7:0] lane_a_data,
    input  wire logic       lane_is_k,
    output logic            lane_ready,
    output logic            sync_n
);
    // ************
    // receiver
    // ************
    integer     seed = 34;
    logic [2:0] comma_q;
    // sync stays released once seen, so re-enabled links resync at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_ready <= 1'b0;
            sync_n <= 1'b0;
            comma_q <= 3'h0;
        end else begin
            lane_ready <= !stall && ($random(seed) % 4 != 0);
            if (lane_valid && lane_is_k && lane_a_data == 8'hbc
                && comma_q != 3'h4) begin
                comma_q <= comma_q + 3'h1;
            end
            sync_n <= comma_q == 3'h4;
        end
    end
endmodule
`default_nettype wire

// >>> tb/serial_link_tx_sva.sv
// port assertions for the serial link transmitter
`timescale 1ns/100ps
`default_nettype none
module serial_link_tx_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic        lane_ready,
    input wire logic        lane_valid,
    input wire logic [7:0]  lane_a_data,
    input wire logic [7:0]  lane_b_data,
    input wire logic        serial_hold_low,
    input wire logic        serial_hold_high,
    input wire logic        serializer_on
);
    // ************
    // checks
    // ************
    logic acc;
    logic rd;
    logic mapped;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = paddr[1:0] == 2'b00 && paddr[13:2] inside
        {12'h200, 12'h205, 12'h206, 12'h207, 12'h20f};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (acc |->
        pready && pslverr == !mapped)
        else $error("apb answer or error flag wrong");
    err_zero_a: assert property (rd && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    id_lsb_a: assert property (rd && paddr == 14'h818 |->
        prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("identifier read bad");
    sel_width_a: assert property (rd && paddr == 14'h814 |->
        prdata[31:4] == 28'h0) else $error("selector high bits set");
    frame_end_char_select_width_a: assert property (rd && paddr == 14'h81c |->
        prdata[31:2] == 30'h0) else $error("end char high bits set");
    off_quiet_a: assert property (!serializer_on ##1
        !serializer_on |->
        !lane_valid && lane_a_data == 8'h00 && lane_b_data == 8'h00
        && !serial_hold_low && !serial_hold_high)
        else $error("lane active while link disabled");
    hold_low_a: assert property (serial_hold_low |->
        !serial_hold_high &&
        lane_a_data == 8'h00 && lane_b_data == 8'h00)
        else $error("held low output wrong");
    hold_high_a: assert property (serial_hold_high |->
        lane_a_data == 8'hff && lane_b_data == 8'hff)
        else $error("held high output wrong");
    lane_hold_a: assert property (serializer_on &&
        $past(serializer_on)
        && !$past(lane_ready) |-> $stable(lane_a_data) && $stable(lane_b_data))
        else $error("lane octet changed without ready");
    buf_full_a: assert property ($fell(sample_ready) |-> $past(sample_valid))
        else $error("buffer filled without a push");
endmodule
bind serial_link_tx serial_link_tx_sva u_serial_link_tx_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .lane_ready(lane_ready),
    .lane_valid(lane_valid), .lane_a_data(lane_a_data),
    .lane_b_data(lane_b_data), .serial_hold_low(serial_hold_low),
    .serial_hold_high(serial_hold_high), .serializer_on(serializer_on));
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the serial link transmitter
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ************
    // signals
    // ************
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, last_rd;
    logic        sample_valid, sample_ready, sync_n, sysref, stall;
    logic        lane_ready, lane_valid, lane_is_k, hold_lo, hold_hi, ser_on;
    logic [7:0]  sample_data, lane_a, lane_b, did_exp, last_s;
    logic [8:0]  seen, e;
    logic [1:0]  fc;
    logic        data_on, k4_seen, prev_rdy;
    logic [32:0] rq[$];
    logic [8:0]  dq[$];
    logic [18:0] tq[$];
    logic [7:0]  end_chr[3] = '{8'hfc, 8'h3c, 8'hbc};
    logic [22:0] tcase[6] = '{{4'h6, 19'h0b5b5}, {4'h7, 19'h1bcbc},
                              {4'ha, 19'h40000}, {4'hb, 19'h2ffff},
                              {4'h1, 19'h00202}, {4'h9, 19'h0bebe}};
    integer      seed, err_total, check_count, ila_count;

    always #50 pclk = ~pclk;

    serial_link_tx u_serial_link_tx (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data),
        .sync_n(sync_n), .sysref(sysref), .lane_ready(lane_ready),
        .lane_valid(lane_valid), .lane_a_data(lane_a), .lane_b_data(lane_b),
        .lane_is_k(lane_is_k), .serial_hold_low(hold_lo),
        .serial_hold_high(hold_hi), .serializer_on(ser_on));

    lane_receiver_model u_lane_receiver_model (
        .pclk(pclk), .presetn(presetn), .stall(stall),
        .lane_valid(lane_valid), .lane_a_data(lane_a), .lane_is_k(lane_is_k),
        .lane_ready(lane_ready), .sync_n(sync_n));

    // ************
    // tasks
    // ************
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) err_total++;
        last_rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [13:0] a, input logic [32:0] exp);
        rq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    // a repeated octet may go out as end char, or as the multiframe mark
    task automatic send(input logic [7:0] s);
        int k;
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_data <= s;
        dq.push_back(s == last_s ? {1'b1, end_chr[fc]} : {1'b0, s});
        last_s = s;
        k = 0;
        do begin @(posedge pclk); k++; end
            while (sample_ready !== 1'b1 && k < 500);
        sample_valid <= 1'b0;
    endtask

    task automatic run_link(input logic [3:0] code, input logic [18:0] exp);
        int k;
        apb(1'b1, 14'h814, {28'h0, code});
        apb(1'b1, 14'h800, 32'h1);
        if (code != 4'h0) tq.push_back(exp);
        else begin
            k = 0;
            do begin apb(1'b0, 14'h83c, 32'h0); k++; end
                while (last_rd[2:0] !== 3'h3 && k < 200);
            @(posedge pclk);
            data_on = 1'b1;
            last_s = 8'h00;
            stall <= 1'b1;
            send(8'($random(seed)) | 8'h01);
            send(last_s);
            @(posedge pclk);
            check(sample_ready, 33'h0);
            stall <= 1'b0;
            send(last_s ^ 8'h5a);
            send(8'($random(seed)));
        end
        repeat (400) if (dq.size() + tq.size() != 0) @(posedge pclk);
        check(33'(dq.size() + tq.size()), 33'h0);
        data_on = 1'b0;
        apb(1'b1, 14'h800, 32'h0);
    endtask

    // ************
    // monitor
    // ************
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && rq.size() != 0)
            check({pslverr, prdata}, rq.pop_front());
        if (lane_valid && prev_rdy) begin
            if (k4_seen) begin
                check({lane_a, lane_b}, {did_exp, did_exp + 8'h01});
                ila_count++;
            end
            k4_seen = lane_is_k && lane_a == 8'h9c;
            if (data_on && dq.size() != 0) begin
                seen = {lane_is_k, lane_a};
                e = dq.pop_front();
                if (e[8] && seen == 9'h17c) seen = e;
                check(seen, e);
            end
            if (tq.size() != 0)
                check({hold_lo, hold_hi, lane_is_k, lane_a, lane_b},
                      tq.pop_front());
        end
        prev_rdy <= lane_ready;
    end

    initial begin
        repeat (30000) @(posedge pclk);
        err_total++;
        report_and_stop;
    end

    // ************
    // sequence
    // ************
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; sample_valid = 0; sample_data = 0;
        sysref = 0; stall = 0; seed = 34; err_total = 0; check_count = 0;
        ila_count = 0; data_on = 0; k4_seen = 0; prev_rdy = 0;
        last_s = 0; fc = 0; did_exp = 0; last_rd = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(14'h814, 33'h0);
        rd(14'h818, 33'h0);
        rd(14'h81c, 33'h0);
        rd(14'h804, {1'b1, 32'h0});
        did_exp = 8'($random(seed)) | 8'h01;
        apb(1'b1, 14'h818, {24'h0, did_exp});
        did_exp[0] = 1'b0;
        rd(14'h818, {25'h0, did_exp});
        apb(1'b1, 14'h814, 32'hff);
        rd(14'h814, 33'h0f);
        rd(14'h815, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) begin
            fc = i[1:0];
            apb(1'b1, 14'h81c, {24'h0, 6'h3f, fc});
            rd(14'h81c, {31'h0, fc});
            run_link(4'h0, 19'h0);
        end
        check(ila_count, 33'h3);
        for (int i = 0; i < 6; i++)
            run_link(tcase[i][22:19], tcase[i][18:0]);
        report_and_stop;
    end
endmodule
`default_nettype wire
